// *** core/lepm_top.sv ***
// Link energy power manager: state machine, timers and registers
`timescale 1ns/10ps
`default_nettype none
module lepm_top #(
    parameter int CYC_PER_MS = lepm_pkg::CYC_PER_MS_DEF
) (
    input wire logic CLK_SYS, // System clock
    input wire logic SYS_RST, // Synchronous reset, high
    input wire logic [3:0] REG_ADDR, // Register address
    input wire logic [15:0] REG_WDATA, // Write data
    input wire logic REG_WR, // Write strobe
    input wire logic REG_RD, // Read strobe
    output logic [15:0] REG_RDATA, // Read data, cycle after strobe
    input wire logic ENERGY_DET, // Media energy level, async
    input wire logic LINK_UP, // Link status from core
    output logic CORE_PWR_EN, // Major blocks powered
    output logic MGMT_PWR_EN, // Management and interrupt pin powered
    output logic ENERGY_MON_EN, // Media energy monitor on
    output logic PWR_DOWN, // Manual power-down level
    output logic FLP_BURST_A, // Send burst on pair A
    output logic FLP_BURST_B, // Send burst on pair B
    output logic [2:0] PM_STATE // Current state, one-hot
);
    typedef lepm_pkg::lepm_state_t st_t;
    default clocking cb_sys @(posedge CLK_SYS);
    endclocking
    default disable iff (SYS_RST);

    // ==========================================================
    // Energy synchroniser
    logic [2:0] sync_q;
    logic energy_q, energy_d;

    always_comb begin
        energy_d = energy_q;
        if (sync_q[1] == sync_q[2]) begin
            energy_d = sync_q[2];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            sync_q <= 3'h0;
            energy_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], ENERGY_DET};
            energy_q <= energy_d;
        end
    end

    // ==========================================================
    // Registers
    logic [15:0] ctrl_q, ctrl_d, rdata_q, rdata_d, stat;
    logic pm_en, an_en, forced_q, forced_d;
    logic [1:0] sleep_sel, wake_sel, lsto_sel, bcnt_q, bcnt_d;
    st_t state_q, state_d;

    assign pm_en = ctrl_q[lepm_pkg::CTRL_PM_EN_BIT];
    assign an_en = ctrl_q[lepm_pkg::CTRL_AN_EN_BIT];
    assign sleep_sel = ctrl_q[lepm_pkg::CTRL_SLEEP_LSB +: 2];
    assign wake_sel = ctrl_q[lepm_pkg::CTRL_WAKE_LSB +: 2];
    assign lsto_sel = {ctrl_q[lepm_pkg::CTRL_LSTO_HI_BIT], ctrl_q[lepm_pkg::CTRL_LSTO_LO_BIT]};

    always_comb begin
        stat = 16'h0000;
        stat[lepm_pkg::STAT_STATE_LSB +: 3] = state_q;
        stat[lepm_pkg::STAT_ENERGY_BIT] = energy_q;
        stat[lepm_pkg::STAT_LINK_BIT] = LINK_UP;
        stat[lepm_pkg::STAT_FORCED_BIT] = forced_q;
        stat[lepm_pkg::STAT_BURST_LSB +: 2] = bcnt_q;
    end

    always_comb begin
        ctrl_d = ctrl_q;
        rdata_d = 16'h0000;
        if (REG_WR && REG_ADDR == lepm_pkg::LEPM_CTRL_ADDR) begin
            ctrl_d = {7'h00, REG_WDATA[8:0]};
        end
        if (REG_RD) begin
            unique case (REG_ADDR)
                lepm_pkg::LEPM_CTRL_ADDR: rdata_d = ctrl_q;
                lepm_pkg::LEPM_STAT_ADDR: rdata_d = stat;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ctrl_q <= lepm_pkg::CTRL_RESET;
            rdata_q <= 16'h0000;
        end else begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;

    // ==========================================================
    // Randomised sleep time, fixed wake and link timer values
    logic [15:0] lfsr_q, lfsr_d, sleep_ms, wake_ms, lsto_ms;
    logic [7:0] rnd;
    logic [31:0] sleep_cyc, wake_cyc, lsto_cyc;
    localparam logic [31:0] BURST_CYC = 32'(lepm_pkg::BURST_GAP_MS * CYC_PER_MS);
    localparam logic [31:0] SLEEP_RST_CYC = 32'(lepm_pkg::SLEEP_MS_1 * CYC_PER_MS);

    assign lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    assign rnd = (lfsr_q[7:0] >= 8'(lepm_pkg::RAND_SPAN)) ?
        lfsr_q[7:0] - 8'(lepm_pkg::RAND_SPAN) : lfsr_q[7:0];

    always_comb begin
        unique case (sleep_sel)
            2'h0: sleep_ms = 16'(lepm_pkg::SLEEP_MS_0);
            2'h1: sleep_ms = 16'(lepm_pkg::SLEEP_MS_1);
            2'h2: sleep_ms = 16'(lepm_pkg::SLEEP_MS_2);
            2'h3: sleep_ms = 16'(lepm_pkg::SLEEP_MS_3);
        endcase
        sleep_ms = sleep_ms + {8'h00, rnd} - 16'(lepm_pkg::RAND_NEG_MS);
        unique case (wake_sel)
            2'h0: wake_ms = 16'(lepm_pkg::WAKE_MS_0);
            2'h1: wake_ms = 16'(lepm_pkg::WAKE_MS_1);
            2'h2: wake_ms = 16'(lepm_pkg::WAKE_MS_2);
            2'h3: wake_ms = 16'(lepm_pkg::WAKE_MS_3);
        endcase
        unique case (lsto_sel)
            2'h0: lsto_ms = 16'(lepm_pkg::LSTO_MS_0);
            2'h1: lsto_ms = 16'(lepm_pkg::LSTO_MS_1);
            2'h2: lsto_ms = 16'(lepm_pkg::LSTO_MS_2);
            2'h3: lsto_ms = 16'(lepm_pkg::LSTO_MS_3);
        endcase
    end

    assign sleep_cyc = 32'({16'h0000, sleep_ms} * 32'(CYC_PER_MS));
    assign wake_cyc = 32'({16'h0000, wake_ms} * 32'(CYC_PER_MS));
    assign lsto_cyc = 32'({16'h0000, lsto_ms} * 32'(CYC_PER_MS));

    // ==========================================================
    // State machine
    logic st_load, st_done, b_load, b_done;
    logic [31:0] st_val;
    logic pair_q, pair_d, burst_a_q, burst_a_d, burst_b_q, burst_b_d, core_q, core_d;

    always_comb begin
        state_d = state_q;
        forced_d = forced_q;
        st_load = 1'b0;
        st_val = lsto_cyc;
        if (!pm_en) begin
            state_d = lepm_pkg::ST_NORM;
            forced_d = 1'b0;
            st_load = 1'b1;
        end else begin
            unique case (state_q)
                lepm_pkg::ST_LOW: begin
                    if (energy_q) begin
                        state_d = lepm_pkg::ST_NORM;
                        forced_d = !an_en;
                        st_load = 1'b1;
                    end else if (st_done) begin
                        state_d = lepm_pkg::ST_WAKE;
                        st_load = 1'b1;
                        st_val = wake_cyc;
                    end
                end
                lepm_pkg::ST_WAKE: begin
                    if (energy_q) begin
                        state_d = lepm_pkg::ST_NORM;
                        forced_d = !an_en;
                        st_load = 1'b1;
                    end else if (st_done) begin
                        state_d = lepm_pkg::ST_LOW;
                        st_load = 1'b1;
                        st_val = sleep_cyc;
                    end
                end
                lepm_pkg::ST_NORM: begin
                    if (LINK_UP) begin
                        st_load = 1'b1;
                    end else if (st_done && an_en && !forced_q) begin
                        state_d = lepm_pkg::ST_LOW;
                        st_load = 1'b1;
                        st_val = sleep_cyc;
                    end
                end
            endcase
        end
    end

    // Burst sequencing inside the wake-up state
    always_comb begin
        bcnt_d = bcnt_q;
        pair_d = pair_q;
        burst_a_d = 1'b0;
        burst_b_d = 1'b0;
        b_load = 1'b0;
        if (state_d != lepm_pkg::ST_WAKE) begin
            bcnt_d = 2'h0;
            pair_d = 1'b0;
        end else if (state_q != lepm_pkg::ST_WAKE ||
                     (b_done && bcnt_q < 2'(lepm_pkg::BURST_MAX))) begin
            bcnt_d = bcnt_q + 2'h1;
            pair_d = !pair_q;
            burst_a_d = !pair_q;
            burst_b_d = pair_q;
            b_load = 1'b1;
        end
        core_d = (state_d == lepm_pkg::ST_NORM);
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state_q <= lepm_pkg::ST_LOW;
            forced_q <= 1'b0;
            lfsr_q <= lepm_pkg::LFSR_SEED;
            bcnt_q <= 2'h0;
            pair_q <= 1'b0;
            burst_a_q <= 1'b0;
            burst_b_q <= 1'b0;
            core_q <= 1'b0;
        end else begin
            state_q <= state_d;
            forced_q <= forced_d;
            lfsr_q <= lfsr_d;
            bcnt_q <= bcnt_d;
            pair_q <= pair_d;
            burst_a_q <= burst_a_d;
            burst_b_q <= burst_b_d;
            core_q <= core_d;
        end
    end

    lepm_timer #(.W(32), .RST_VAL(SLEEP_RST_CYC)) u_state_tmr (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .load(st_load),
        .load_val(st_val),
        .done(st_done)
    );

    lepm_timer #(.W(32), .RST_VAL(32'h0000_0000)) u_burst_tmr (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .load(b_load),
        .load_val(BURST_CYC - 32'h0000_0001), // Zero cycle counts, gap is exact
        .done(b_done)
    );

    assign CORE_PWR_EN = core_q && !ctrl_q[lepm_pkg::CTRL_PDOWN_BIT];
    assign MGMT_PWR_EN = 1'b1;
    assign ENERGY_MON_EN = 1'b1;
    assign PWR_DOWN = ctrl_q[lepm_pkg::CTRL_PDOWN_BIT];
    assign FLP_BURST_A = burst_a_q;
    assign FLP_BURST_B = burst_b_q;
    assign PM_STATE = state_q;

    // ==========================================================
    // Assertions
    sequence s_enter_wake;
        state_q != lepm_pkg::ST_WAKE ##1 state_q == lepm_pkg::ST_WAKE;
    endsequence
    sequence s_wake_done;
        pm_en && state_q == lepm_pkg::ST_WAKE && !energy_q && st_done;
    endsequence
    property p_reset_low;
        $past(SYS_RST) |-> state_q == lepm_pkg::ST_LOW;
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("not low after reset");
    property p_onehot;
        $onehot(state_q);
    endproperty
    a_onehot: assert property (p_onehot) else $error("state not one-hot");
    property p_energy_norm;
        pm_en && state_q == lepm_pkg::ST_LOW && energy_q |=> state_q == lepm_pkg::ST_NORM;
    endproperty
    a_energy_norm: assert property (p_energy_norm) else $error("energy ignored");
    property p_disable_norm;
        !pm_en |=> state_q == lepm_pkg::ST_NORM && !st_done;
    endproperty
    a_disable_norm: assert property (p_disable_norm) else $error("disable not normal");
    property p_sleep_wake;
        pm_en && state_q == lepm_pkg::ST_LOW && !energy_q && st_done |=>
            state_q == lepm_pkg::ST_WAKE;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("no wake after sleep");
    property p_wake_low;
        s_wake_done |=> state_q == lepm_pkg::ST_LOW && !st_done;
    endproperty
    a_wake_low: assert property (p_wake_low) else $error("wake not ending low");
    property p_forced_stay;
        pm_en && state_q == lepm_pkg::ST_NORM && (forced_q || !an_en) |=>
            state_q == lepm_pkg::ST_NORM;
    endproperty
    a_forced_stay: assert property (p_forced_stay) else $error("left normal when forced");
    property p_first_burst;
        s_enter_wake |-> FLP_BURST_A && !FLP_BURST_B && bcnt_q == 2'h1;
    endproperty
    a_first_burst: assert property (p_first_burst) else $error("no first burst");
    property p_burst_max;
        bcnt_q == 2'(lepm_pkg::BURST_MAX) |-> !burst_a_d && !burst_b_d;
    endproperty
    a_burst_max: assert property (p_burst_max) else $error("too many bursts");
    property p_low_core_off;
        state_q != lepm_pkg::ST_NORM |-> !CORE_PWR_EN && MGMT_PWR_EN;
    endproperty
    a_low_core_off: assert property (p_low_core_off) else $error("core on in low");
    property p_rand_range;
        sleep_sel == 2'h1 |-> sleep_ms >= 16'(lepm_pkg::SLEEP_MS_1 - lepm_pkg::RAND_NEG_MS) &&
            sleep_ms <= 16'(lepm_pkg::SLEEP_MS_1 + lepm_pkg::RAND_POS_MS);
    endproperty
    a_rand_range: assert property (p_rand_range) else $error("sleep out of range");
    property p_pdown;
        REG_WR && REG_ADDR == lepm_pkg::LEPM_CTRL_ADDR |=> PWR_DOWN == $past(REG_WDATA[2]);
    endproperty
    a_pdown: assert property (p_pdown) else $error("power-down not taken");
endmodule
`default_nettype wire

// *** core/lepm_pkg.sv ***
// Package of constants for the link energy power manager
package lepm_pkg;
    // ==========================================================
    // Register map
    localparam logic [3:0] LEPM_CTRL_ADDR = 4'h0;
    localparam logic [3:0] LEPM_STAT_ADDR = 4'h1;
    localparam int LEPM_DW = 16;

    // ==========================================================
    // Control field positions
    localparam int CTRL_PM_EN_BIT = 0;
    localparam int CTRL_AN_EN_BIT = 1;
    localparam int CTRL_PDOWN_BIT = 2;
    localparam int CTRL_SLEEP_LSB = 3;
    localparam int CTRL_WAKE_LSB = 5;
    localparam int CTRL_LSTO_LO_BIT = 7;
    localparam int CTRL_LSTO_HI_BIT = 8;
    localparam logic [15:0] CTRL_RESET = 16'h000A;

    // ==========================================================
    // Status field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_ENERGY_BIT = 3;
    localparam int STAT_LINK_BIT = 4;
    localparam int STAT_FORCED_BIT = 5;
    localparam int STAT_BURST_LSB = 6;

    // ==========================================================
    // Times
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_MS = 1000000;
    localparam int CYC_PER_MS_DEF = NS_PER_MS / CLK_PERIOD_NS;
    localparam int SLEEP_MS_0 = 1000;
    localparam int SLEEP_MS_1 = 2000;
    localparam int SLEEP_MS_2 = 3000;
    localparam int SLEEP_MS_3 = 4000;
    localparam int WAKE_MS_0 = 100;
    localparam int WAKE_MS_1 = 200;
    localparam int WAKE_MS_2 = 400;
    localparam int WAKE_MS_3 = 800;
    localparam int LSTO_MS_0 = 2000;
    localparam int LSTO_MS_1 = 1000;
    localparam int LSTO_MS_2 = 3000;
    localparam int LSTO_MS_3 = 4000;
    localparam int RAND_NEG_MS = 80;
    localparam int RAND_POS_MS = 60;
    localparam int RAND_SPAN = RAND_NEG_MS + RAND_POS_MS + 1;
    localparam int BURST_GAP_MS = 16;
    localparam int BURST_MAX = 3;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;

    // ==========================================================
    // States
    typedef enum logic [2:0] {
        ST_LOW = 3'b001,
        ST_WAKE = 3'b010,
        ST_NORM = 3'b100
    } lepm_state_t;
endpackage

// *** core/lepm_timer.sv ***
// Loadable down-counter used for the power manager timers
`timescale 1ns/10ps
`default_nettype none
module lepm_timer #(
    parameter int W = 32,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic load, // Reload request
    input wire logic [W-1:0] load_val, // Value to reload
    output logic done // Count has reached zero
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = load_val;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= RST_VAL;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == '0);
endmodule
`default_nettype wire

// *** dv/lepm_partner.sv ***
// Far-end partner model: sleeps until woken by a burst, then shows energy and link
`timescale 1ns/10ps
`default_nettype none
module lepm_partner (
    input wire logic clk, // System clock
    input wire logic burst_a, // Burst seen on pair A
    input wire logic burst_b, // Burst seen on pair B
    input wire logic plug, // Cable attached, partner powered
    input wire logic [15:0] wake_dly, // Cycles from burst to answer
    output logic energy, // Energy on the media
    output logic link // Link status seen by the core
);
    int cnt = -1;
    int up = 0;
    initial begin
        energy = 1'b0;
        link = 1'b0;
    end
    // ==========================================================
    // Wake on burst, answer after a delay, link follows energy
    always @(posedge clk) begin
        if (!plug) begin
            cnt <= -1;
            up <= 0;
            energy <= 1'b0;
            link <= 1'b0;
        end else if (!energy) begin
            if (cnt < 0 && (burst_a || burst_b)) begin
                cnt <= int'(wake_dly);
            end else if (cnt == 0) begin
                energy <= 1'b1;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end else begin
            up <= up + 1;
            if (up == 50) begin
                link <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Testbench for the link energy power manager
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int C = 2;
    localparam lepm_pkg::lepm_state_t SL = lepm_pkg::ST_LOW;
    localparam lepm_pkg::lepm_state_t SW = lepm_pkg::ST_WAKE;
    localparam lepm_pkg::lepm_state_t SN = lepm_pkg::ST_NORM;
    localparam logic [3:0] CA = lepm_pkg::LEPM_CTRL_ADDR;
    localparam logic [3:0] SA = lepm_pkg::LEPM_STAT_ADDR;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic plug = 1'b0;
    logic [15:0] wake_dly = 16'h0005;
    logic [15:0] reg_rdata;
    logic energy, link, core_pwr, mgmt_pwr, mon_en, pwr_down, burst_a, burst_b;
    logic [2:0] pm_state;
    logic [2:0] prev = 3'h0;
    logic [15:0] rdv;
    int fails = 0;
    int checked = 0;
    int n = 0;
    int wcyc = 0;
    int nb = 0;
    int sl[4] = '{1000, 2000, 3000, 4000};
    int wk[4] = '{100, 200, 400, 800};

    always #5 clk_sys = ~clk_sys;

    lepm_top #(.CYC_PER_MS(C)) i_lepm_top (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ENERGY_DET(energy),
        .LINK_UP(link), .CORE_PWR_EN(core_pwr), .MGMT_PWR_EN(mgmt_pwr),
        .ENERGY_MON_EN(mon_en), .PWR_DOWN(pwr_down), .FLP_BURST_A(burst_a),
        .FLP_BURST_B(burst_b), .PM_STATE(pm_state)
    );
    lepm_partner i_lepm_partner (
        .clk(clk_sys), .burst_a(burst_a), .burst_b(burst_b), .plug(plug),
        .wake_dly(wake_dly), .energy(energy), .link(link)
    );

    // ==========================================================
    // Compare helpers and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rng(input int v, input int lo, input int hi);
        checked++;
        if (v < lo || v > hi) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wst(input logic [2:0] s, input int lim, output int k);
        k = 0;
        while (pm_state !== s && k < lim) begin
            @(posedge clk_sys);
            #1 k++;
        end
        if (k >= lim) chk(pm_state, s);
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Per-cycle watch of state, power enables and bursts
    always @(negedge clk_sys) begin
        if (!sys_rst) begin
            chk(pm_state == SL || pm_state == SW || pm_state == SN, 1'b1);
            chk({mgmt_pwr, mon_en}, 2'b11);
            if (pm_state !== SN && prev !== SN) chk(core_pwr, 1'b0);
            if (pm_state === SW) begin
                if (prev !== SW) begin
                    wcyc = 0;
                    nb = 0;
                end
                if (burst_a || burst_b) begin
                    chk(wcyc, nb * 16 * C);
                    chk({burst_a, burst_b}, {~nb[0], nb[0]});
                    nb++;
                end
                wcyc++;
            end else begin
                chk({burst_a, burst_b}, 2'b00);
            end
        end
        prev = pm_state;
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1 chk({pm_state, core_pwr, pwr_down}, {SL, 2'b00});
        wst(SN, 5, n);
        rd(CA, rdv);
        chk(rdv, 16'h000A);
        rd(4'hF, rdv);
        chk(rdv, 16'h0000);
        wr(4'h3, 16'hFFFF);
        rd(CA, rdv);
        chk(rdv, 16'h000A);
        wr(CA, 16'h0082);
        wr(CA, 16'h0083);
        wst(SL, 1100 * C, n);
        rng(n, 1000 * C - 3, 1000 * C + 8);
        for (int i = 0; i < 4; i++) begin
            wst(SW, 4200 * C, n);
            wr(CA, {9'h001, 2'(i), 2'(i), 3'h3});
            wst(SL, 2000 * C, n);
            wst(SW, 4200 * C, n);
            rng(n, (sl[i] - 80) * C - 3, (sl[i] + 60) * C + 3);
            wst(SL, 2000 * C, n);
            rng(n, wk[i] * C - 2, wk[i] * C + 3);
            chk(nb, 3);
        end
        wr(CA, 16'h0082);
        wst(SN, 4, n);
        wr(CA, 16'h0083);
        wst(SL, 1100 * C, n);
        plug <= 1'b1;
        wst(SN, 1300 * C, n);
        repeat (60) @(posedge clk_sys);
        rd(SA, rdv);
        chk(rdv[5:0], 6'b011100);
        chk(core_pwr, 1'b1);
        plug <= 1'b0;
        wst(SL, 1100 * C, n);
        rng(n, 1000 * C - 1, 1000 * C + 8);
        wr(CA, 16'h0103);
        wake_dly <= 16'h0190;
        plug <= 1'b1;
        wst(SN, 1500 * C, n);
        plug <= 1'b0;
        wst(SL, 3100 * C, n);
        rng(n, 3000 * C - 1, 3000 * C + 8);
        wr(CA, 16'h0083);
        wake_dly <= 16'h0005;
        plug <= 1'b1;
        wst(SN, 1300 * C, n);
        repeat (60) @(posedge clk_sys);
        wr(CA, 16'h0081);
        plug <= 1'b0;
        repeat (1000 * C + 100) @(posedge clk_sys);
        chk(pm_state, SN);
        wr(CA, 16'h0082);
        wr(CA, 16'h0083);
        wst(SL, 1100 * C, n);
        wr(CA, 16'h0081);
        wst(SW, 1300 * C, n);
        wst(SL, 300 * C, n);
        plug <= 1'b1;
        wst(SN, 1300 * C, n);
        rd(SA, rdv);
        chk(rdv[5], 1'b1);
        plug <= 1'b0;
        repeat (1000 * C + 100) @(posedge clk_sys);
        chk(pm_state, SN);
        wr(CA, 16'h0006);
        repeat (2) @(posedge clk_sys);
        chk({pm_state, pwr_down, core_pwr}, {SN, 2'b10});
        wr(CA, 16'h0002);
        repeat (2) @(posedge clk_sys);
        chk({pwr_down, core_pwr}, 2'b01);
        end_sim();
    end

    initial begin
        #950_000;
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
